// File: src/bpa_pkg.sv
// Package for the bidirectional port A block: register map and constants.
// Assumes an AHB-Lite slave at word offsets, one 40 MHz system clock.
package bpa_pkg;

	localparam int unsigned PORT_WIDTH = 8;

	// Register byte offsets.
	localparam logic [7:0] PIN_LEVEL_OFS = 8'h00;
	localparam logic [7:0] LATCH_OFS     = 8'h04;
	localparam logic [7:0] DIR_OFS       = 8'h08;
	localparam logic [7:0] CFG_OFS       = 8'h0C;

	// Reset values.
	localparam logic [7:0] DIR_RST   = 8'hFF;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] CFG_RST   = 8'h00;

	// Bit positions of the shared pins.
	localparam int unsigned OPEN_DRAIN_BIT = 4;
	localparam int unsigned OSC_LO_BIT     = 6;
	localparam int unsigned OSC_HI_BIT     = 7;

	// Analog-capable pins (bits 0..3 and 5).
	localparam logic [7:0] ANALOG_MASK  = 8'h2F;
	// Pins shared with LCD segment drives (bits 2..5).
	localparam logic [7:0] SEGMENT_MASK = 8'h3C;

	// Cycle clock output divides the system clock by four.
	localparam logic [1:0] CYCLE_DIV_LAST = 2'h3;

	// AHB-Lite transfer and response codes.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic       HRESP_OKAY    = 1'h0;

	// Oscillator mode codes presented by the configuration logic.
	typedef enum logic [2:0]
	{
		OSC_CRYSTAL,
		OSC_EXT_CLOCK,
		OSC_RC,
		OSC_RC_IO,
		OSC_INTERNAL,
		OSC_INTERNAL_IO,
		OSC_EXT_CLOCK_IO
	} bpa_osc_mode_e;

	// Pin bundle toward the pads.
	typedef struct packed
	{
		logic [7:0] out;
		logic [7:0] oe;
	} bpa_pad_s;

	// Select signals from neighbouring peripherals.
	typedef struct packed
	{
		logic [7:0] analogSel;
		logic [7:0] segmentEn;
	} bpa_alt_s;

endpackage : bpa_pkg

// File: src/bpa_port.sv
// Eight-bit bidirectional general-purpose port with alternate functions.
// Assumes an AHB-Lite master on sys_clk; pins are asynchronous to it.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Eight pins, each with its own bits.
// - Direction, pin-level and latch registers.
// - Direction bit 1 releases the pin.
// - Direction bit 0 drives latch value.
// - Pin-level reads pins; writes go to latch.
// - Latch register reads back latched value.
// - Enabled alternate function takes the pin.
// - Bits six, seven read zero unless port.
// - Bit six is I/O in I/O oscillator modes.
// - Otherwise bit six drives cycle clock.
// - Bit seven I/O only in internal modes.
// - Bit four Schmitt input, open-drain output.
// - Bit four input feeds timer clock.
// - Converter configuration selects analog pins.
// - Analog pins still driven when output.
// - Analog default at reset; reads zero.
// - Direction bits still rule analog pins.
// - Enabled segment overrides bits two to five.
module bpa_port
	import bpa_pkg::*;
(
	input  wire logic                   sys_clk,         // System clock.
	input  wire logic                   rst_n,           // Async reset.
	input  wire logic                   hsel,            // Slave select.
	input  wire logic [7:0]             haddr,           // Byte address.
	input  wire logic [1:0]             htrans,          // Transfer type.
	input  wire logic                   hwrite,          // Write access.
	input  wire logic [2:0]             hsize,           // Transfer size.
	input  wire logic [31:0]            hwdata,          // Write data.
	input  wire logic                   hready,          // Bus ready.
	output logic      [31:0]            hrdata,          // Read data.
	output logic                        hreadyout,       // Slave ready.
	output logic                        hresp,           // Response.
	input  wire logic [7:0]             pinIn,           // Pad levels.
	output bpa_pkg::bpa_pad_s           pad,             // Pad drive.
	input  wire bpa_pkg::bpa_alt_s      altSel,          // Peripheral selects.
	input  wire bpa_pkg::bpa_osc_mode_e oscMode,         // Oscillator mode.
	output logic                        timerExtClockIn  // Timer clock input.
);
	import bpa_pkg::*;

	// Register storage.
	logic [7:0] dirQ;
	logic [7:0] latchQ;
	logic [7:0] cfgQ;

	// Synchroniser stages for pads and peripheral selects.
	logic [7:0] syncA;
	logic [7:0] syncB;
	logic [7:0] altA;
	logic [7:0] altB;
	logic [7:0] altSegA;
	logic [7:0] altSegB;

	// Bus data-phase state.
	logic       wrPendQ;
	logic [7:0] wrAddrQ;
	logic       accept;
	logic       wrDir;
	logic       wrLatch;
	logic       wrCfg;

	// Cycle clock divider.
	logic [1:0] divQ;
	logic       cycleTick;
	logic       cycleClkQ;

	// Pin ownership, read values and next pad drive.
	logic       osc6Io;
	logic       osc7Io;
	logic       drainPinIn;
	logic [7:0] portMask;
	logic [7:0] analogSel;
	logic [7:0] segOwn;
	logic [7:0] readPins;
	logic [7:0] rdLatch;
	logic [7:0] rdDir;
	logic [7:0] outNext;
	logic [7:0] oeNext;
	logic [7:0] rdNext;

	// A transfer is taken when selected, ready and not idle or busy.
	assign accept = hsel && hready
		&& (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

	// Write strobes decoded from the captured data-phase address.
	assign wrDir   = wrPendQ && (wrAddrQ == DIR_OFS);
	assign wrLatch = wrPendQ
		&& (wrAddrQ == LATCH_OFS || wrAddrQ == PIN_LEVEL_OFS);
	assign wrCfg   = wrPendQ && (wrAddrQ == CFG_OFS);

	// Bit six is released only in the I/O-releasing oscillator modes.
	assign osc6Io = (oscMode == OSC_RC_IO) || (oscMode == OSC_INTERNAL_IO)
		|| (oscMode == OSC_EXT_CLOCK_IO);

	// Bit seven is I/O only while an internal oscillator runs.
	assign osc7Io = (oscMode == OSC_INTERNAL)
		|| (oscMode == OSC_INTERNAL_IO);

	// Unreleased oscillator pins read zero in the pin-level, latch and direction registers; the configuration register is not masked.
	assign portMask = {osc7Io, osc6Io, 6'h3F};

	// Low configuration bits select analog, so reset leaves pins analog.
	assign analogSel = (~cfgQ | altB) & ANALOG_MASK;

	// Only pins two to five can be taken by a segment drive.
	assign segOwn = altSegB & SEGMENT_MASK;

	// Analog pins and unreleased oscillator pins read zero.
	assign readPins = syncB & ~analogSel & portMask;
	assign rdLatch  = latchQ & portMask;
	assign rdDir    = dirQ & portMask;

	// The Schmitt input of the open-drain pin also clocks the timer.
	assign drainPinIn = syncB[OPEN_DRAIN_BIT];

	// Two-flop synchroniser for the pad levels.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA <= 8'h00;
			syncB <= 8'h00;
		end
		else
		begin
			syncA <= pinIn;
			syncB <= syncA;
		end
	end

	// Two-flop synchroniser for the external analog selects.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			altA <= 8'h00;
			altB <= 8'h00;
		end
		else
		begin
			altA <= altSel.analogSel;
			altB <= altA;
		end
	end

	// Two-flop synchroniser for the segment enables.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			altSegA <= 8'h00;
			altSegB <= 8'h00;
		end
		else
		begin
			altSegA <= altSel.segmentEn;
			altSegB <= altSegA;
		end
	end

	// A write is pending for the data phase that follows its address.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPendQ <= 1'h0;
		end
		else if (hready)
		begin
			wrPendQ <= accept && hwrite;
		end
	end

	// The address is held so the data phase knows its target.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrAddrQ <= 8'h00;
		end
		else if (hready)
		begin
			wrAddrQ <= haddr;
		end
	end

	// Direction register; ones release the pins.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dirQ <= DIR_RST;
		end
		else if (wrDir)
		begin
			dirQ <= hwdata[7:0];
		end
	end

	// Output latch, written through either the latch or pin-level offset.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			latchQ <= LATCH_RST;
		end
		else if (wrLatch)
		begin
			latchQ <= hwdata[7:0];
		end
	end

	// Converter configuration; a low bit keeps its pin analog.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfgQ <= CFG_RST;
		end
		else if (wrCfg)
		begin
			cfgQ <= hwdata[7:0];
		end
	end

	// Read data mux on the address-phase address.
	always_comb
	begin
		case (haddr)
			PIN_LEVEL_OFS: rdNext = readPins;
			LATCH_OFS:     rdNext = rdLatch;
			DIR_OFS:       rdNext = rdDir;
			CFG_OFS:       rdNext = cfgQ;
			default:       rdNext = 8'h00;
		endcase
	end

	// Read data is registered so it stands through the data phase.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hrdata <= 32'h0000_0000;
		end
		else if (accept && !hwrite)
		begin
			hrdata <= {24'h00_0000, rdNext};
		end
	end

	// The slave never inserts wait states.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hreadyout <= 1'h1;
		end
		else
		begin
			hreadyout <= 1'h1;
		end
	end

	// Every transfer completes with an OKAY response.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hresp <= HRESP_OKAY;
		end
		else
		begin
			hresp <= HRESP_OKAY;
		end
	end

	// Free-running divide-by-four counter.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			divQ <= 2'h0;
		end
		else
		begin
			divQ <= divQ + 2'h1;
		end
	end

	// One-cycle enable at each half period of the cycle clock.
	assign cycleTick = (divQ == CYCLE_DIV_LAST) || (divQ == 2'h1);

	// Cycle clock at one quarter of the system clock rate.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cycleClkQ <= 1'h0;
		end
		else if (cycleTick)
		begin
			cycleClkQ <= ~cycleClkQ;
		end
	end

	// Pad drive for each pin; alternate owners win in priority order.
	genvar i;
	generate
		for (i = 0; i < PORT_WIDTH; i++)
		begin : g_pin
			always_comb
			begin
				outNext[i] = latchQ[i];
				oeNext[i]  = ~dirQ[i];
				if (segOwn[i])
				begin
					// An enabled segment drive overrides direction.
					outNext[i] = 1'h0;
					oeNext[i]  = 1'h0;
				end
				else if (i == OPEN_DRAIN_BIT)
				begin
					// Open drain: pull low only, release on a latched one.
					outNext[i] = 1'h0;
					oeNext[i]  = ~dirQ[i] & ~latchQ[i];
				end
				else if (i == OSC_LO_BIT && !osc6Io)
				begin
					outNext[i] = cycleClkQ;
					oeNext[i]  = 1'h1;
				end
				else if (i == OSC_HI_BIT && !osc7Io)
				begin
					// The oscillator input owns the pin.
					outNext[i] = 1'h0;
					oeNext[i]  = 1'h0;
				end
			end
		end
	endgenerate

	// Registered pad drive and enables.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pad.out <= 8'h00;
			pad.oe  <= 8'h00;
		end
		else
		begin
			pad.out <= outNext;
			pad.oe  <= oeNext;
		end
	end

	// Timer clock input from the synchronised open-drain pin level.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timerExtClockIn <= 1'h0;
		end
		else
		begin
			timerExtClockIn <= drainPinIn;
		end
	end

endmodule : bpa_port // bpa_port

`default_nettype wire

// File: bench/bpa_port_checker.sv
// Concurrent checks on the port block's outputs.
// Assumes hsel and hready stay high and oscMode moves only in reset.
`timescale 1ns/1ps
`default_nettype none
module bpa_port_checker
	import bpa_pkg::*;
(
	input wire logic                   sys_clk,        // Clock.
	input wire logic                   rst_n,          // Reset.
	input wire logic [7:0]             haddr,          // Address.
	input wire logic [1:0]             htrans,         // Transfer.
	input wire logic                   hwrite,         // Write.
	input wire logic [31:0]            hrdata,         // Read data.
	input wire logic                   hreadyout,      // Ready.
	input wire logic                   hresp,          // Response.
	input wire logic [7:0]             pinIn,          // Pins.
	input wire bpa_pkg::bpa_pad_s      pad,            // Pad drive.
	input wire bpa_pkg::bpa_alt_s      altSel,         // Selects.
	input wire bpa_pkg::bpa_osc_mode_e oscMode,        // Mode.
	input wire logic                   timerExtClockIn // Timer in.
);
	logic       rdReg_q;
	logic       rdPin_q;
	logic       io6;
	logic [7:0] hide;
	assign io6 = oscMode inside {OSC_RC_IO, OSC_INTERNAL_IO, OSC_EXT_CLOCK_IO};
	assign hide = {!(oscMode inside {OSC_INTERNAL, OSC_INTERNAL_IO}), !io6,
		6'h00};
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdReg_q <= 1'h0;
		else
			rdReg_q <= htrans[1] && !hwrite && haddr < CFG_OFS;
	end
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdPin_q <= 1'h0;
		else
			rdPin_q <= htrans[1] && !hwrite && haddr == PIN_LEVEL_OFS;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence cycWave;
		pad.out[6] [*2] ##1 !pad.out[6] [*2] ##1 pad.out[6];
	endsequence
	bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
		else $error("bus response wrong");
	upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	drain_low_a: assert property (pad.oe[4] |-> !pad.out[4])
		else $error("open-drain pin driven high");
	osc_hi_off_a: assert property (hide[7] |-> !pad.oe[7])
		else $error("oscillator input pin driven");
	cyc_drive_a: assert property (!io6 && $past(rst_n) |-> pad.oe[6])
		else $error("cycle clock pin not driven");
	cyc_wave_a: assert property (!io6 && $rose(pad.out[6]) |-> cycWave)
		else $error("cycle clock not a quarter rate");
	seg_override_a: assert property ($stable(altSel.segmentEn) [*4]
		|-> (pad.oe & altSel.segmentEn & SEGMENT_MASK) == 8'h00)
		else $error("segment pin still driven");
	timer_follow_a: assert property ($stable(pinIn[4]) [*4]
		##0 $past(rst_n, 4) |-> timerExtClockIn == pinIn[4])
		else $error("timer clock input lags pin");
	analog_zero_a: assert property ($stable(altSel.analogSel) [*4]
		##0 rdPin_q |-> (hrdata[7:0] & altSel.analogSel & ANALOG_MASK) == 8'h00)
		else $error("analog pin read not zero");
	hidden_zero_a: assert property (rdReg_q |-> (hrdata[7:0] & hide) == 8'h00)
		else $error("oscillator bits read not zero");
endmodule // bpa_port_checker
bind bpa_port bpa_port_checker chk_u (.sys_clk, .rst_n, .haddr, .htrans,
	.hwrite, .hrdata, .hreadyout, .hresp, .pinIn, .pad, .altSel, .oscMode,
	.timerExtClockIn);
`default_nettype wire

// File: bench/bpa_pin_model.sv
// Board model: a pin follows the port where it drives, else the board.
// Assumes the board drives every pin that the port releases.
`timescale 1ns/1ps
`default_nettype none
module bpa_pin_model
	import bpa_pkg::*;
(
	input  wire bpa_pkg::bpa_pad_s pad,    // Port drive.
	input  wire logic [7:0]        extDrv, // Board level.
	output logic [7:0]             pinIn   // Pin level.
);
	assign pinIn = (pad.oe & pad.out) | (~pad.oe & extDrv);
endmodule // bpa_pin_model
`default_nettype wire

// File: bench/bpa_port_tb.sv
// Self-checking bench for the port block beside a board pin model.
// Assumes zero-wait bus answers and a 40 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module bpa_port_tb;
	import bpa_pkg::*;
	logic          sys_clk = 1'h0;
	logic          rst_n = 1'h0;
	logic [7:0]    haddr = 8'h00;
	logic [1:0]    htrans = 2'h0;
	logic          hwrite = 1'h0;
	logic [31:0]   hwdata = 32'h00000000;
	logic [31:0]   hrdata;
	logic          hreadyout;
	logic          hresp;
	logic [7:0]    pinIn;
	logic [7:0]    extDrv = 8'h00;
	bpa_pad_s      pad;
	bpa_alt_s      altSel = 16'h0000;
	bpa_osc_mode_e oscMode = OSC_CRYSTAL;
	logic          timerExtClockIn;
	logic [7:0]    dirM, latM, cfgM, hideM, anaM, pinE;
	logic [15:0]   padE, mskE;
	logic [31:0]   rd;
	int            seed = 372;
	int            errTotal = 0;
	int            cmpCount = 0;
	int            cycles = 0;
	always #12.5 sys_clk = ~sys_clk;
	bpa_port dut_u (.sys_clk, .rst_n, .hsel(1'h1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .pinIn, .pad, .altSel, .oscMode, .timerExtClockIn);
	bpa_pin_model pins_u (.pad, .extDrv, .pinIn);
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errTotal++;
			conclude();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		cmpCount++;
		if (g !== e)
		begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge sys_clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge sys_clk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic rdChk(input string n, input logic [7:0] a, e);
		xfer(a, 1'h0, 8'h00);
		chk(n, {24'h000000, e}, rd);
	endtask
	// Predicts pad drive and pin reads from the shadow registers.
	function automatic void model();
		anaM = ANALOG_MASK & (~cfgM | altSel.analogSel);
		hideM = {!(oscMode inside {OSC_INTERNAL, OSC_INTERNAL_IO}),
			!(oscMode inside {OSC_RC_IO, OSC_INTERNAL_IO, OSC_EXT_CLOCK_IO}),
			6'h00};
		padE[7:0] = ~dirM & ~hideM & ~(altSel.segmentEn & SEGMENT_MASK);
		padE[4] = padE[4] & ~latM[4];
		padE[15:8] = latM & padE[7:0] & 8'hEF;
		pinE = (padE[15:8] | (~padE[7:0] & extDrv)) & ~hideM & ~anaM;
		mskE = ~{2{hideM & 8'h40}};
	endfunction
	initial
	begin
		for (int m = 0; m < 7; m++)
		begin
			rst_n <= 1'h0;
			oscMode <= bpa_osc_mode_e'(m);
			extDrv <= 8'($random(seed));
			repeat (4) @(posedge sys_clk);
			rst_n <= 1'h1;
			dirM = DIR_RST;
			latM = LATCH_RST;
			cfgM = CFG_RST;
			repeat (4) @(posedge sys_clk);
			model();
			rdChk("dir", DIR_OFS, DIR_RST & ~hideM);
			rdChk("latch", LATCH_OFS, LATCH_RST);
			rdChk("config", CFG_OFS, CFG_RST);
			rdChk("unmapped", 8'h10, 8'h00);
			rdChk("pins", PIN_LEVEL_OFS, pinE);
			for (int k = 0; k < 6; k++)
			begin
				altSel <= 16'($random(seed) & $random(seed));
				extDrv <= 8'($random(seed));
				cfgM = 8'($random(seed));
				latM = 8'($random(seed));
				xfer(CFG_OFS, 1'h1, cfgM);
				xfer(k[0] ? LATCH_OFS : PIN_LEVEL_OFS, 1'h1, latM);
				model();
				dirM = 8'($random(seed)) | anaM;
				xfer(DIR_OFS, 1'h1, dirM);
				repeat (5) @(posedge sys_clk);
				model();
				chk("pad", {16'h0000, padE & mskE},
					{16'h0000, {pad.out & pad.oe, pad.oe} & mskE});
				chk("timer", {31'h0, pinE[4]}, {31'h0, timerExtClockIn});
				rdChk("pins", PIN_LEVEL_OFS, pinE);
				rdChk("latch", LATCH_OFS, latM & ~hideM);
				rdChk("dir", DIR_OFS, dirM & ~hideM);
			end
			$display("oscillator mode %0d done", m);
		end
		conclude();
	end
endmodule // bpa_port_tb
`default_nettype wire
